//--- rtl/dacdp_cfg.svh
`ifndef DACDP_CFG_SVH
`define DACDP_CFG_SVH
`define DACDP_AW 12
`define DACDP_A_UPD 12'h113
`define DACDP_A_FTW0 12'h114
`define DACDP_A_FTW1 12'h115
`define DACDP_A_FTW2 12'h116
`define DACDP_A_TUNING_WORD_BYTE3 12'h117
`define DACDP_A_TUNING_WORD_BYTE4 12'h118
`define DACDP_A_TUNING_WORD_BYTE5 12'h119
`define DACDP_A_PHS0 12'h11A
`define DACDP_A_PHS1 12'h11B
`define DACDP_A_CMP0 12'h11C
`define DACDP_A_CMP1 12'h11D
`define DACDP_A_TXC 12'h11F
`define DACDP_A_RC0 12'h121
`define DACDP_A_RC1 12'h122
`define DACDP_A_FC0 12'h123
`define DACDP_A_FC1 12'h124
`define DACDP_A_DPS 12'h12D
`define DACDP_A_TMC 12'h12F
`define DACDP_A_TMP0 12'h132
`define DACDP_A_TMP1 12'h133
`define DACDP_A_TMU 12'h134
`define DACDP_A_DCC 12'h135
`define DACDP_A_IO0 12'h136
`define DACDP_A_IO1 12'h137
`define DACDP_A_QO0 12'h138
`define DACDP_A_QO1 12'h139
`define DACDP_A_IO2 12'h13A
`define DACDP_Z8 8'h00
`define DACDP_Z16 16'h0000
`define DACDP_Z48 48'h000000000000
`define DACDP_Z5 5'h00
`define DACDP_Z13 13'h0000
`define DACDP_R_TUNING_WORD_BYTE5 8'h10
`define DACDP_R_FALL 2'h2
`define DACDP_R_RISE 2'h0
`define DACDP_R_PIN 1'h1
`define DACDP_R_SM 1'h1
`define DACDP_R_RC0 8'h0F
`define DACDP_R_RC1 8'h00
`define DACDP_R_FC 8'hFF
`define DACDP_R_DPS 8'h46
`define DACDP_R_TMRSV 7'h10
`define DACDP_B_SM 0
`define DACDP_B_PIN 1
`define DACDP_B_INV 2
`define DACDP_B_REQ 0
`define DACDP_B_ACK 1
`define DACDP_B_EN 0
`define DACDP_F_RISE 5:4
`define DACDP_F_FALL 7:6
`define DACDP_F_HI5 4:0
`define DACDP_F_RSV 7:1
`define DACDP_CTL_IMM 2'h0
`define DACDP_CNT1 16'h0001
`endif

//--- rtl/dacdp_pkg.sv
package dacdp_pkg;
  typedef enum logic [1:0] {
    TXG_OFF,
    TXG_RISE,
    TXG_ON,
    TXG_FALL
  } dacdp_txg_state_t;
  typedef logic [7:0] dacdp_byte_t;
endpackage

//--- rtl/dacdp_tx_if.sv
`timescale 1ns/1ps
interface dacdp_tx_if;
  logic sm_on;
  logic pin_sel;
  logic pol_flip;
  logic [1:0] rise_ctl;
  logic [1:0] fall_ctl;
  logic [15:0] rise_cnt;
  logic [15:0] fall_cnt;
  logic amp_on;
  modport cfg (output sm_on, pin_sel, pol_flip, rise_ctl, fall_ctl, rise_cnt, fall_cnt, input amp_on);
  modport gate (input sm_on, pin_sel, pol_flip, rise_ctl, fall_ctl, rise_cnt, fall_cnt, output amp_on);
endinterface

//--- rtl/dacdp_tx_gate.sv
`timescale 1ns/1ps
`include "dacdp_cfg.svh"
module dacdp_tx_gate (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic transmit_gate_i,
  input wire logic sync_i,
  dacdp_tx_if.gate tx,
  output logic shared_pin_o
);
  dacdp_pkg::dacdp_txg_state_t st_q;
  logic [15:0] cnt_q;

  // Amplifier enable follows the gate after the programmed counts
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_q <= dacdp_pkg::TXG_OFF;
      cnt_q <= `DACDP_Z16;
      tx.amp_on <= 1'b0;
    end else if (!tx.sm_on) begin
      // Machine stopped: enable tracks the gate directly
      st_q <= transmit_gate_i ? dacdp_pkg::TXG_ON : dacdp_pkg::TXG_OFF;
      cnt_q <= `DACDP_Z16;
      tx.amp_on <= transmit_gate_i;
    end else begin
      unique case (st_q)
        dacdp_pkg::TXG_OFF: begin
          if (transmit_gate_i) begin
            if (tx.rise_ctl == `DACDP_CTL_IMM) begin
              st_q <= dacdp_pkg::TXG_ON;
              tx.amp_on <= 1'b1;
            end else begin
              st_q <= dacdp_pkg::TXG_RISE;
              cnt_q <= tx.rise_cnt;
            end
          end
        end
        dacdp_pkg::TXG_RISE: begin
          if (!transmit_gate_i) begin
            st_q <= dacdp_pkg::TXG_OFF;
          end else if (cnt_q == `DACDP_Z16) begin
            st_q <= dacdp_pkg::TXG_ON;
            tx.amp_on <= 1'b1;
          end else begin
            cnt_q <= cnt_q - `DACDP_CNT1;
          end
        end
        dacdp_pkg::TXG_ON: begin
          if (!transmit_gate_i) begin
            if (tx.fall_ctl == `DACDP_CTL_IMM) begin
              st_q <= dacdp_pkg::TXG_OFF;
              tx.amp_on <= 1'b0;
            end else begin
              st_q <= dacdp_pkg::TXG_FALL;
              cnt_q <= tx.fall_cnt;
            end
          end
        end
        dacdp_pkg::TXG_FALL: begin
          // Gate back during fall keeps the amplifier on, no glitch
          if (transmit_gate_i) begin
            st_q <= dacdp_pkg::TXG_ON;
          end else if (cnt_q == `DACDP_Z16) begin
            st_q <= dacdp_pkg::TXG_OFF;
            tx.amp_on <= 1'b0;
          end else begin
            cnt_q <= cnt_q - `DACDP_CNT1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      shared_pin_o <= 1'b0;
    end else if (tx.pin_sel) begin
      shared_pin_o <= tx.amp_on ^ tx.pol_flip;
    end else begin
      shared_pin_o <= sync_i;
    end
  end
endmodule // dacdp_tx_gate

//--- rtl/dacdp_regs.sv
`timescale 1ns/1ps
`include "dacdp_cfg.svh"
// Function
// - 48-bit tuning word from six bytes, all held here
// - 16-bit oscillator phase shift from two bytes
// - 13-bit phase compensation word from two bytes
// - Gate machine enable plus rise/fall controls
// - Bit 2 flips amplifier control polarity
// - Bit 1 puts amplifier control on pin
// - Temperature converter runs only when enabled
// - Read-only 16-bit temperature readback
// - Refresh bit latches a fresh temperature code while the converter runs
// - Offset correction applies only when enabled
// - 16-bit I offset first part
// - 16-bit Q offset first part
// - 5-bit I offset second part
// - Tuning update request answered by acknowledge
module dacdp_regs (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [`DACDP_AW-1:0] cfg_addr_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_wdata_i,
  output logic [7:0] cfg_rdata_o,
  output logic cfg_rvalid_o,
  input wire logic transmit_gate_i,
  input wire logic sync_i,
  input wire logic [15:0] temp_code_i,
  output logic shared_pin_o,
  output logic [47:0] osc_tuning_word_o,
  output logic [15:0] osc_phase_shift_o,
  output logic [12:0] phase_comp_word_o,
  output logic [7:0] datapath_setup_o,
  output logic aux_temp_converter_on_o,
  output logic offset_correction_on_o,
  output logic [15:0] i_offset_first_o,
  output logic [15:0] q_offset_first_o,
  output logic [4:0] i_offset_second_o
);
  dacdp_pkg::dacdp_byte_t ftw_q [6];
  dacdp_pkg::dacdp_byte_t cmp1_q;
  logic [1:0] fall_q;
  logic [1:0] rise_q;
  logic inv_q;
  logic pin_q;
  logic sm_q;
  dacdp_pkg::dacdp_byte_t rc0_q;
  dacdp_pkg::dacdp_byte_t rc1_q;
  dacdp_pkg::dacdp_byte_t fc0_q;
  dacdp_pkg::dacdp_byte_t fc1_q;
  logic [6:0] tmrsv_q;
  logic tmu_q;
  logic [15:0] temp_q;
  dacdp_pkg::dacdp_byte_t io0_q;
  dacdp_pkg::dacdp_byte_t io1_q;
  dacdp_pkg::dacdp_byte_t qo0_q;
  dacdp_pkg::dacdp_byte_t qo1_q;
  logic [4:0] io2_q;
  logic req_q;
  logic ack_q;
  dacdp_pkg::dacdp_byte_t rd_d;
  logic [`DACDP_AW-1:0] ftw_addr [6];

  dacdp_tx_if txi ();

  assign ftw_addr[0] = `DACDP_A_FTW0;
  assign ftw_addr[1] = `DACDP_A_FTW1;
  assign ftw_addr[2] = `DACDP_A_FTW2;
  assign ftw_addr[3] = `DACDP_A_TUNING_WORD_BYTE3;
  assign ftw_addr[4] = `DACDP_A_TUNING_WORD_BYTE4;
  assign ftw_addr[5] = `DACDP_A_TUNING_WORD_BYTE5;

  // Shadow tuning bytes; the active word moves only on the handshake
  for (genvar g = 0; g < 6; g++) begin : g_ftw
    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        ftw_q[g] <= (g == 5) ? `DACDP_R_TUNING_WORD_BYTE5 : `DACDP_Z8;
      end else if (cfg_wr_i && cfg_addr_i == ftw_addr[g]) begin
        ftw_q[g] <= cfg_wdata_i;
      end
    end
  end

  // Request is software owned; acknowledge is raised by hardware
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      req_q <= 1'b0;
    end else if (cfg_wr_i && cfg_addr_i == `DACDP_A_UPD) begin
      req_q <= cfg_wdata_i[`DACDP_B_REQ];
    end
  end

  // Ack drops only after the request is cleared, so one request loads once
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      osc_tuning_word_o <= {`DACDP_R_TUNING_WORD_BYTE5, `DACDP_Z8, `DACDP_Z8, `DACDP_Z8, `DACDP_Z8, `DACDP_Z8};
    end else if (req_q && !ack_q) begin
      ack_q <= 1'b1;
      osc_tuning_word_o <= {ftw_q[5], ftw_q[4], ftw_q[3], ftw_q[2], ftw_q[1], ftw_q[0]};
    end else if (!req_q) begin
      ack_q <= 1'b0;
    end
  end

  // Phase bytes land straight in the output flops, no extra stage
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      osc_phase_shift_o <= `DACDP_Z16;
    end else if (cfg_wr_i && cfg_addr_i == `DACDP_A_PHS0) begin
      osc_phase_shift_o[7:0] <= cfg_wdata_i;
    end else if (cfg_wr_i && cfg_addr_i == `DACDP_A_PHS1) begin
      osc_phase_shift_o[15:8] <= cfg_wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cmp1_q <= `DACDP_Z8;
      phase_comp_word_o <= `DACDP_Z13;
    end else if (cfg_wr_i && cfg_addr_i == `DACDP_A_CMP0) begin
      phase_comp_word_o[7:0] <= cfg_wdata_i;
    end else if (cfg_wr_i && cfg_addr_i == `DACDP_A_CMP1) begin
      // Upper byte is stored whole but only five bits reach the word
      cmp1_q <= cfg_wdata_i;
      phase_comp_word_o[12:8] <= cfg_wdata_i[`DACDP_F_HI5];
    end
  end

  // Bit 3 is reserved and always reads zero
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      fall_q <= `DACDP_R_FALL;
      rise_q <= `DACDP_R_RISE;
      inv_q <= 1'b0;
      pin_q <= `DACDP_R_PIN;
      sm_q <= `DACDP_R_SM;
    end else if (cfg_wr_i && cfg_addr_i == `DACDP_A_TXC) begin
      fall_q <= cfg_wdata_i[`DACDP_F_FALL];
      rise_q <= cfg_wdata_i[`DACDP_F_RISE];
      inv_q <= cfg_wdata_i[`DACDP_B_INV];
      pin_q <= cfg_wdata_i[`DACDP_B_PIN];
      sm_q <= cfg_wdata_i[`DACDP_B_SM];
    end
  end

  // Counts are taken when a delay starts; later writes wait for the next edge
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rc0_q <= `DACDP_R_RC0;
      rc1_q <= `DACDP_R_RC1;
      fc0_q <= `DACDP_R_FC;
      fc1_q <= `DACDP_R_FC;
    end else if (cfg_wr_i) begin
      if (cfg_addr_i == `DACDP_A_RC0) begin
        rc0_q <= cfg_wdata_i;
      end
      if (cfg_addr_i == `DACDP_A_RC1) begin
        rc1_q <= cfg_wdata_i;
      end
      if (cfg_addr_i == `DACDP_A_FC0) begin
        fc0_q <= cfg_wdata_i;
      end
      if (cfg_addr_i == `DACDP_A_FC1) begin
        fc1_q <= cfg_wdata_i;
      end
    end
  end

  assign txi.sm_on = sm_q;
  assign txi.pin_sel = pin_q;
  assign txi.pol_flip = inv_q;
  assign txi.rise_ctl = rise_q;
  assign txi.fall_ctl = fall_q;
  assign txi.rise_cnt = {rc1_q, rc0_q};
  assign txi.fall_cnt = {fc1_q, fc0_q};

  // Gate timing lives in its own module so its counter stays local
  dacdp_tx_gate u_tx_gate (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .transmit_gate_i(transmit_gate_i),
    .sync_i(sync_i),
    .tx(txi.gate),
    .shared_pin_o(shared_pin_o)
  );

  // Power-on value is not the working one; software must rewrite it
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      datapath_setup_o <= `DACDP_R_DPS;
    end else if (cfg_wr_i && cfg_addr_i == `DACDP_A_DPS) begin
      datapath_setup_o <= cfg_wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      tmrsv_q <= `DACDP_R_TMRSV;
      aux_temp_converter_on_o <= 1'b0;
    end else if (cfg_wr_i && cfg_addr_i == `DACDP_A_TMC) begin
      tmrsv_q <= cfg_wdata_i[`DACDP_F_RSV];
      aux_temp_converter_on_o <= cfg_wdata_i[0];
    end
  end

  // Stored bit only reads back; the refresh itself is the write strobe
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      tmu_q <= 1'b0;
    end else if (cfg_wr_i && cfg_addr_i == `DACDP_A_TMU) begin
      tmu_q <= cfg_wdata_i[0];
    end
  end

  // A code is only taken while the converter runs; else the old one stays
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      temp_q <= `DACDP_Z16;
    end else if (cfg_wr_i && cfg_addr_i == `DACDP_A_TMU && cfg_wdata_i[0] && aux_temp_converter_on_o) begin
      temp_q <= temp_code_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      offset_correction_on_o <= 1'b0;
    end else if (cfg_wr_i && cfg_addr_i == `DACDP_A_DCC) begin
      offset_correction_on_o <= cfg_wdata_i[`DACDP_B_EN];
    end
  end

  // Stored parts are kept while correction is off, ready for re-enable
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      io0_q <= `DACDP_Z8;
      io1_q <= `DACDP_Z8;
      qo0_q <= `DACDP_Z8;
      qo1_q <= `DACDP_Z8;
      io2_q <= 5'h00;
    end else if (cfg_wr_i) begin
      if (cfg_addr_i == `DACDP_A_IO0) begin
        io0_q <= cfg_wdata_i;
      end
      if (cfg_addr_i == `DACDP_A_IO1) begin
        io1_q <= cfg_wdata_i;
      end
      if (cfg_addr_i == `DACDP_A_QO0) begin
        qo0_q <= cfg_wdata_i;
      end
      if (cfg_addr_i == `DACDP_A_QO1) begin
        qo1_q <= cfg_wdata_i;
      end
      if (cfg_addr_i == `DACDP_A_IO2) begin
        io2_q <= cfg_wdata_i[`DACDP_F_HI5];
      end
    end
  end

  // Correction values reach the datapath only while it is switched on
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      i_offset_first_o <= `DACDP_Z16;
      q_offset_first_o <= `DACDP_Z16;
      i_offset_second_o <= `DACDP_Z5;
    end else if (cfg_wr_i && cfg_addr_i == `DACDP_A_DCC) begin
      // Enable change loads the stored parts or clears the outputs
      i_offset_first_o <= cfg_wdata_i[`DACDP_B_EN] ? {io1_q, io0_q} : `DACDP_Z16;
      q_offset_first_o <= cfg_wdata_i[`DACDP_B_EN] ? {qo1_q, qo0_q} : `DACDP_Z16;
      i_offset_second_o <= cfg_wdata_i[`DACDP_B_EN] ? io2_q : `DACDP_Z5;
    end else if (cfg_wr_i && offset_correction_on_o) begin
      if (cfg_addr_i == `DACDP_A_IO0) begin
        i_offset_first_o[7:0] <= cfg_wdata_i;
      end
      if (cfg_addr_i == `DACDP_A_IO1) begin
        i_offset_first_o[15:8] <= cfg_wdata_i;
      end
      if (cfg_addr_i == `DACDP_A_QO0) begin
        q_offset_first_o[7:0] <= cfg_wdata_i;
      end
      if (cfg_addr_i == `DACDP_A_QO1) begin
        q_offset_first_o[15:8] <= cfg_wdata_i;
      end
      if (cfg_addr_i == `DACDP_A_IO2) begin
        i_offset_second_o <= cfg_wdata_i[`DACDP_F_HI5];
      end
    end
  end

  // Unmapped addresses read zero; reserved bits too, except TMC bits 7:1 and CMP1 bits 7:5, which read back as written
  always_comb begin
    rd_d = `DACDP_Z8;
    unique case (cfg_addr_i)
      `DACDP_A_UPD: rd_d = {6'h00, ack_q, req_q};
      `DACDP_A_FTW0: rd_d = ftw_q[0];
      `DACDP_A_FTW1: rd_d = ftw_q[1];
      `DACDP_A_FTW2: rd_d = ftw_q[2];
      `DACDP_A_TUNING_WORD_BYTE3: rd_d = ftw_q[3];
      `DACDP_A_TUNING_WORD_BYTE4: rd_d = ftw_q[4];
      `DACDP_A_TUNING_WORD_BYTE5: rd_d = ftw_q[5];
      `DACDP_A_PHS0: rd_d = osc_phase_shift_o[7:0];
      `DACDP_A_PHS1: rd_d = osc_phase_shift_o[15:8];
      `DACDP_A_CMP0: rd_d = phase_comp_word_o[7:0];
      `DACDP_A_CMP1: rd_d = cmp1_q;
      `DACDP_A_TXC: rd_d = {fall_q, rise_q, 1'b0, inv_q, pin_q, sm_q};
      `DACDP_A_RC0: rd_d = rc0_q;
      `DACDP_A_RC1: rd_d = rc1_q;
      `DACDP_A_FC0: rd_d = fc0_q;
      `DACDP_A_FC1: rd_d = fc1_q;
      `DACDP_A_DPS: rd_d = datapath_setup_o;
      `DACDP_A_TMC: rd_d = {tmrsv_q, aux_temp_converter_on_o};
      `DACDP_A_TMP0: rd_d = temp_q[7:0];
      `DACDP_A_TMP1: rd_d = temp_q[15:8];
      `DACDP_A_TMU: rd_d = {7'h00, tmu_q};
      `DACDP_A_DCC: rd_d = {7'h00, offset_correction_on_o};
      `DACDP_A_IO0: rd_d = io0_q;
      `DACDP_A_IO1: rd_d = io1_q;
      `DACDP_A_QO0: rd_d = qo0_q;
      `DACDP_A_QO1: rd_d = qo1_q;
      `DACDP_A_IO2: rd_d = {3'h0, io2_q};
      default: rd_d = `DACDP_Z8;
    endcase
  end

  // Read data is held until the next read strobe
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cfg_rdata_o <= `DACDP_Z8;
      cfg_rvalid_o <= 1'b0;
    end else begin
      cfg_rvalid_o <= cfg_rd_i;
      if (cfg_rd_i) begin
        cfg_rdata_o <= rd_d;
      end
    end
  end
endmodule // dacdp_regs

//--- tb/dacdp_regs_properties.sv
`timescale 1ns/1ps
`include "dacdp_cfg.svh"
module dacdp_props (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [`DACDP_AW-1:0] cfg_addr_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_wdata_i,
  input wire logic [7:0] cfg_rdata_o,
  input wire logic [47:0] osc_tuning_word_o,
  input wire logic [15:0] osc_phase_shift_o,
  input wire logic [12:0] phase_comp_word_o,
  input wire logic [7:0] datapath_setup_o,
  input wire logic aux_temp_converter_on_o,
  input wire logic offset_correction_on_o,
  input wire logic [15:0] i_offset_first_o,
  input wire logic [15:0] q_offset_first_o,
  input wire logic [4:0] i_offset_second_o
);
  logic upd_wr;
  assign upd_wr = cfg_wr_i && cfg_addr_i == `DACDP_A_UPD && cfg_wdata_i[0];
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  setup_write_a: assert property (
    cfg_wr_i && cfg_addr_i == `DACDP_A_DPS |=> datapath_setup_o == $past(cfg_wdata_i)) else $error("setup byte lost");
  setup_read_a: assert property (
    cfg_rd_i && cfg_addr_i == `DACDP_A_DPS |=> cfg_rdata_o == $past(datapath_setup_o)) else $error("setup readback");
  phase_low_a: assert property (
    cfg_wr_i && cfg_addr_i == `DACDP_A_PHS0 |=> osc_phase_shift_o[7:0] == $past(cfg_wdata_i)) else $error("phase low");
  comp_high_a: assert property (
    cfg_wr_i && cfg_addr_i == `DACDP_A_CMP1 |=> phase_comp_word_o[12:8] == $past(cfg_wdata_i[4:0]))
    else $error("comp high");
  conv_enable_a: assert property (
    cfg_wr_i && cfg_addr_i == `DACDP_A_TMC |=> aux_temp_converter_on_o == $past(cfg_wdata_i[0]))
    else $error("converter enable");
  corr_enable_a: assert property (
    cfg_wr_i && cfg_addr_i == `DACDP_A_DCC |=> offset_correction_on_o == $past(cfg_wdata_i[0]))
    else $error("correction enable");
  // Gated outputs must read zero so a disabled module adds no offset
  offset_gated_a: assert property (
    !offset_correction_on_o |-> {i_offset_first_o, q_offset_first_o, i_offset_second_o} == 37'h0000000000)
    else $error("offset not gated");
  q_offset_a: assert property (
    cfg_wr_i && cfg_addr_i == `DACDP_A_QO1 && offset_correction_on_o ##1 offset_correction_on_o
    |-> q_offset_first_o[15:8] == $past(cfg_wdata_i)) else $error("q offset high");
  second_rsv_a: assert property (
    cfg_rd_i && cfg_addr_i == `DACDP_A_IO2 |=> cfg_rdata_o[7:5] == 3'h0) else $error("reserved bits set");
  tuning_hold_a: assert property (
    !$stable(osc_tuning_word_o) |-> $past(upd_wr, 2)) else $error("tuning word moved without request");
  cover property (upd_wr);
  cover property (offset_correction_on_o && q_offset_first_o != 16'h0000);
  cover property (cfg_rd_i && cfg_addr_i == `DACDP_A_TMP0);
endmodule // dacdp_props
bind dacdp_regs dacdp_props u_props (.mclk_i, .rst_i, .cfg_addr_i, .cfg_wr_i, .cfg_rd_i, .cfg_wdata_i, .cfg_rdata_o,
  .osc_tuning_word_o, .osc_phase_shift_o, .phase_comp_word_o, .datapath_setup_o, .aux_temp_converter_on_o,
  .offset_correction_on_o, .i_offset_first_o, .q_offset_first_o, .i_offset_second_o);

//--- tb/test_dac_datapath_ctrl_regs.sv
`timescale 1ns/1ps
`include "dacdp_cfg.svh"
module test_dac_datapath_ctrl_regs;
  logic mclk_i, rst_i, cfg_wr_i, cfg_rd_i, transmit_gate_i, sync_i, cfg_rvalid_o, shared_pin_o;
  logic aux_temp_converter_on_o, offset_correction_on_o, inv;
  logic [11:0] cfg_addr_i, a;
  logic [7:0] cfg_wdata_i, cfg_rdata_o, datapath_setup_o, rb, v;
  logic [15:0] temp_code_i, osc_phase_shift_o, i_offset_first_o, q_offset_first_o, tc;
  logic [47:0] osc_tuning_word_o, tw;
  logic [12:0] phase_comp_word_o;
  logic [4:0] i_offset_second_o;
  logic [7:0] mem [64];
  int bad_count, tests_run, seed, n, d0, k, p;
  dacdp_regs dut (.mclk_i, .rst_i, .cfg_addr_i, .cfg_wr_i, .cfg_rd_i, .cfg_wdata_i, .cfg_rdata_o, .cfg_rvalid_o,
    .transmit_gate_i, .sync_i, .temp_code_i, .shared_pin_o, .osc_tuning_word_o, .osc_phase_shift_o,
    .phase_comp_word_o, .datapath_setup_o, .aux_temp_converter_on_o, .offset_correction_on_o,
    .i_offset_first_o, .q_offset_first_o, .i_offset_second_o);
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  function automatic logic [7:0] rst_val(input logic [11:0] x);
    case (x)
      12'h119: return 8'h10;
      12'h11F: return 8'h83;
      12'h121: return 8'h0F;
      12'h123, 12'h124: return 8'hFF;
      12'h12D: return 8'h46;
      12'h12F: return 8'h20;
      default: return 8'h00;
    endcase
  endfunction
  // Unmapped holes read zero, read-only bytes keep their old content
  function automatic logic [7:0] after_wr(input logic [11:0] x, input logic [7:0] d, input logic [7:0] old);
    case (x)
      12'h132, 12'h133: return old;
      12'h11F: return d & 8'hF7;
      12'h134, 12'h135: return d & 8'h01;
      12'h13A: return d & 8'h1F;
      default: return (x == 12'h11E || x == 12'h120 || (x > 12'h124 && x < 12'h132 && x != 12'h12D && x != 12'h12F))
        ? 8'h00 : d;
    endcase
  endfunction
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t ns: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (bad_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic fail_out();
    $display("wrong value at %0t ns: wait ran out", $time);
    bad_count++;
    summarize();
  endtask
  task automatic wr(input logic [11:0] x, input logic [7:0] d);
    cfg_addr_i = x;
    cfg_wdata_i = d;
    cfg_wr_i = 1'b1;
    @(posedge mclk_i);
    #1 cfg_wr_i = 1'b0;
    @(posedge mclk_i);
    #1;
  endtask
  task automatic rd(input logic [11:0] x);
    int i;
    cfg_addr_i = x;
    cfg_rd_i = 1'b1;
    @(posedge mclk_i);
    #1 cfg_rd_i = 1'b0;
    for (i = 0; i < 4 && cfg_rvalid_o !== 1'b1; i++) @(posedge mclk_i) #1;
    if (cfg_rvalid_o !== 1'b1) fail_out();
    rb = cfg_rdata_o;
    @(posedge mclk_i);
    #1;
  endtask
  // Edges until the pin shows the new level; differences cancel the fixed pipeline
  task automatic meas(input logic g, output int m);
    transmit_gate_i = g;
    m = 0;
    do begin
      @(posedge mclk_i) #1;
      m++;
    end while (shared_pin_o !== (g ^ inv) && m < 60);
    if (m >= 60) fail_out();
  endtask
  initial begin
    {cfg_addr_i, cfg_wdata_i, cfg_wr_i, cfg_rd_i, transmit_gate_i, sync_i, temp_code_i, inv} = '0;
    seed = 32'h3581;
    rst_i = 1'b1;
    repeat (5) @(posedge mclk_i);
    #1 rst_i = 1'b0;
    tw = 48'h100000000000;
    for (a = 12'h113; a <= 12'h13A; a++) begin
      rd(a);
      mem[a[5:0]] = rst_val(a);
      chk(rb, mem[a[5:0]]);
    end
    wr(12'h12D, 8'h8B);
    mem[6'h2D] = 8'h8B;
    chk(datapath_setup_o, 8'h8B);
    for (p = 0; p < 3; p++) begin
      tc = 16'($random(seed));
      temp_code_i = tc;
      for (a = 12'h114; a <= 12'h13A; a++) begin
        v = 8'($random(seed));
        if (a == 12'h135) v[0] = p[0];
        if (a == 12'h12F) v[7:1] = 7'h10;
        wr(a, v);
        if (a == 12'h134 && v[0] && mem[6'h2F][0]) {mem[6'h33], mem[6'h32]} = tc;
        mem[a[5:0]] = after_wr(a, v, mem[a[5:0]]);
        rd(a);
        chk(rb, mem[a[5:0]]);
      end
      chk(osc_phase_shift_o, {mem[6'h1B], mem[6'h1A]});
      chk(phase_comp_word_o, {mem[6'h1D][4:0], mem[6'h1C]});
      chk(aux_temp_converter_on_o, mem[6'h2F][0]);
      chk(offset_correction_on_o, mem[6'h35][0]);
      chk({i_offset_first_o, q_offset_first_o, i_offset_second_o}, mem[6'h35][0] ? {mem[6'h37], mem[6'h36],
        mem[6'h39], mem[6'h38], mem[6'h3A][4:0]} : 37'h0000000000);
      chk(osc_tuning_word_o, tw);
      wr(12'h113, 8'h01);
      k = 0;
      do rd(12'h113); while (rb[1] !== 1'b1 && ++k < 8);
      chk(rb[1], 1'b1);
      tw = {mem[6'h19], mem[6'h18], mem[6'h17], mem[6'h16], mem[6'h15], mem[6'h14]};
      chk(osc_tuning_word_o, tw);
      wr(12'h113, 8'h00);
    end
    wr(12'h12F, 8'h21);
    wr(12'h134, 8'h01);
    rd(12'h132);
    chk(rb, tc[7:0]);
    wr(12'h12F, 8'h20);
    temp_code_i = ~tc;
    wr(12'h134, 8'h01);
    rd(12'h133);
    chk(rb, tc[15:8]);
    wr(12'h11F, 8'h03);
    meas(1'b1, d0);
    meas(1'b0, n);
    chk(n, d0);
    k = $random(seed) & 7;
    wr(12'h121, 8'(k));
    wr(12'h122, 8'h00);
    wr(12'h11F, 8'h13);
    meas(1'b1, n);
    chk(n, d0 + k + 1);
    wr(12'h123, 8'h03);
    wr(12'h124, 8'h00);
    wr(12'h11F, 8'h83);
    meas(1'b0, n);
    chk(n, d0 + 4);
    wr(12'h11F, 8'hF2);
    meas(1'b1, n);
    chk(n, d0);
    inv = 1'b1;
    wr(12'h11F, 8'h07);
    meas(1'b0, n);
    meas(1'b1, n);
    chk(n, d0);
    inv = 1'b0;
    wr(12'h11F, 8'h01);
    sync_i = 1'b1;
    repeat (2) @(posedge mclk_i) #1;
    chk(shared_pin_o, 1'b1);
    sync_i = 1'b0;
    repeat (2) @(posedge mclk_i) #1;
    chk(shared_pin_o, 1'b0);
    summarize();
  end
endmodule // test_dac_datapath_ctrl_regs
